// [hw/relay_panel_io_port.sv]
// Purpose: address decode, register file and relay port logic of the panel
// Assumes: all bus pins are asynchronous to clk; strobes active high
// Notes:   a bus cycle is seen after two flops, so strobes must stay
//          asserted for several clk periods
`timescale 1ns/1ps
`default_nettype none
`include "rpio_params.svh"

module relay_panel_io_port
    import rpio_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    systemReset,
    input  wire logic                    busFailSafe,
    input  wire logic                    codedReadStrobe,
    input  wire logic                    codedWriteStrobe,
    input  wire logic                    busAddrBit5,
    input  wire logic                    busAddrBit0,
    input  wire logic                    panelSelBit4,
    input  wire logic                    panelSelBit3,
    input  wire logic                    panelSelBit2,
    input  wire logic                    panelSelBit1,
    input  wire logic [`RPIO_SEL_W-1:0]  strapClosed,
    input  wire logic [`RPIO_PORT_W-1:0] busDataIn,
    output var  logic [`RPIO_PORT_W-1:0] busDataOut,
    output var  logic                    busDataOe,
    input  wire logic [`RPIO_PORT_W-1:0] leftChanIn,
    input  wire logic [`RPIO_PORT_W-1:0] rightChanIn,
    output var  logic [`RPIO_PORT_W-1:0] leftRelayDrive,
    output var  logic [`RPIO_PORT_W-1:0] rightRelayDrive
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation

    logic [`RPIO_SYNC_W-1:0] pinSync;
    logic                    sysRstS;
    logic                    failS;
    logic                    rdS;
    logic                    wrS;
    logic                    addr5S;
    logic                    addr0S;
    logic [`RPIO_SEL_W-1:0]  selS;
    logic [`RPIO_SEL_W-1:0]  strapS;
    rpio_byte_type           dataS;
    rpio_byte_type           chanInS [`RPIO_PORTS];

    rpio_sync #(
        .WIDTH (`RPIO_SYNC_W)
    ) u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .pinIn   ({systemReset, busFailSafe, codedReadStrobe, codedWriteStrobe,
                   busAddrBit5, busAddrBit0,
                   panelSelBit4, panelSelBit3, panelSelBit2, panelSelBit1,
                   strapClosed, busDataIn, leftChanIn, rightChanIn}),
        .pinSync (pinSync)
    );

    assign {sysRstS, failS, rdS, wrS, addr5S, addr0S, selS, strapS, dataS,
            chanInS[0], chanInS[1]} = pinSync;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    logic [`RPIO_SEL_W-1:0] expectedSel;
    logic                   selected;
    logic                   clearRegs;
    logic                   writePulse;

    // straps are jumpers, so they are sampled continuously rather than once
    assign expectedSel = ~strapS;
    assign selected    = (selS == expectedSel);
    assign clearRegs   = sysRstS | failS;

    ////////////////////////////////////////////////////////////////////////////
    // bus cycle state

    rpio_state_type state_r;
    rpio_state_type state_nxt;

    // a write is taken once, on the way into ST_WRITE, so a long strobe
    // cannot store a byte twice
    assign writePulse = (state_r == ST_IDLE) && selected && wrS && !rdS && !failS;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (failS) begin
                    state_nxt = ST_IDLE;
                end else if (selected && wrS && !rdS) begin
                    state_nxt = ST_WRITE;
                end else if (selected && rdS && !wrS) begin
                    state_nxt = ST_READ;
                end
            end
            ST_WRITE: begin
                if (!wrS || failS) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_READ: begin
                if (!rdS || !selected || failS) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data and direction registers, one pair per port

    rpio_byte_type dataReg_r  [`RPIO_PORTS];
    rpio_byte_type dirReg_r   [`RPIO_PORTS];
    rpio_byte_type portState  [`RPIO_PORTS];
    rpio_byte_type relayDrive [`RPIO_PORTS];

    for (genvar p = 0; p < `RPIO_PORTS; p++) begin : g_port
        always_ff @(posedge clk) begin
            if (!rst_n || clearRegs) begin
                dataReg_r[p] <= `RPIO_DATA_RST;
                dirReg_r[p]  <= `RPIO_DIR_RST;
            end else if (writePulse && (addr5S == 1'(p))) begin
                if (addr0S == `RPIO_REG_DIR) begin
                    dirReg_r[p] <= dataS;
                end else begin
                    dataReg_r[p] <= dataS;
                end
            end
        end

        // output bits echo the data register, input bits show the channel
        assign portState[p] = (dataReg_r[p] & dirReg_r[p])
                            | (~dirReg_r[p] & chanInS[p]);

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                relayDrive[p] <= `RPIO_DATA_RST;
            end else begin
                relayDrive[p] <= dataReg_r[p] & dirReg_r[p];
            end
        end
    end

    assign leftRelayDrive  = relayDrive[0];
    assign rightRelayDrive = relayDrive[1];

    ////////////////////////////////////////////////////////////////////////////
    // read path

    rpio_byte_type readData_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readData_r <= `RPIO_DATA_RST;
        end else begin
            readData_r <= (addr5S == `RPIO_PORT_RIGHT) ? portState[1] : portState[0];
        end
    end

    assign busDataOut = readData_r;
    // driving stops the moment the strobe or select goes; failed cable
    // leaves the bus to the host terminators, which read as FF
    assign busDataOe  = (state_r == ST_READ) && rdS && selected
                        && !wrS && !failS;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_sel_gates_cycle: assert property (
        (state_r == ST_IDLE && !selected) |=> (state_r == ST_IDLE))
        else $error("unselected cycle left idle");

    a_write_left_data: assert property (
        (writePulse && addr5S == `RPIO_PORT_LEFT && addr0S == `RPIO_REG_DATA
         && !clearRegs) |=> (dataReg_r[0] == $past(dataS)))
        else $error("left data write not stored");

    a_write_right_dir: assert property (
        (writePulse && addr5S == `RPIO_PORT_RIGHT && addr0S == `RPIO_REG_DIR
         && !clearRegs) |=> (dirReg_r[1] == $past(dataS) && $stable(dataReg_r[1])))
        else $error("right direction write misplaced");

    a_port_isolation: assert property (
        (writePulse && addr5S == `RPIO_PORT_RIGHT && !clearRegs)
        |=> ($stable(dataReg_r[0]) && $stable(dirReg_r[0])))
        else $error("right write disturbed left port");

    a_reset_clears: assert property (
        clearRegs |=> (dataReg_r[0] == `RPIO_DATA_RST && dirReg_r[0] == `RPIO_DIR_RST
                      && dataReg_r[1] == `RPIO_DATA_RST && dirReg_r[1] == `RPIO_DIR_RST))
        else $error("registers not cleared");

    a_drive_and_gate: assert property (
        ##1 (leftRelayDrive == ($past(dataReg_r[0]) & $past(dirReg_r[0]))
             && rightRelayDrive == ($past(dataReg_r[1]) & $past(dirReg_r[1]))))
        else $error("relay drive not data and direction");

    a_read_value: assert property (
        (busDataOe && $past(rdS) && $stable(addr5S))
        |-> (busDataOut == (addr5S ? $past(portState[1]) : $past(portState[0]))))
        else $error("read data not port state");

    a_input_reads_one: assert property (
        (!dirReg_r[0][0] && chanInS[0][0] && addr5S == `RPIO_PORT_LEFT)
        |=> readData_r[0])
        else $error("active input bit read as 0");

    a_no_drive_write: assert property (
        (wrS || !selected) |-> !busDataOe)
        else $error("data driven outside own read");

    // the relay flops lag the cleared registers by one edge, so the
    // drives are only known to be off two edges after the fail is seen
    a_fail_quiet: assert property (
        failS |-> !busDataOe ##2 (leftRelayDrive == `RPIO_DATA_RST
                                  && rightRelayDrive == `RPIO_DATA_RST))
        else $error("panel active during fail-safe");

    c_write_cycle: cover property (state_r == ST_IDLE ##1 state_r == ST_WRITE);
    c_read_cycle:  cover property (busDataOe [*3]);
    c_fail_clear:  cover property ((rightRelayDrive != 8'h00) ##1 failS);

endmodule

`default_nettype wire

// [hw/rpio_params.svh]
// Purpose: constants of the relay panel port block
// Assumes: included by bare name
// Notes:   offsets, widths and reset values only, no logic
`ifndef RPIO_PARAMS_SVH
`define RPIO_PARAMS_SVH

// register choice from address lines 5 (port) and 0 (register)
`define RPIO_PORT_LEFT     1'h0
`define RPIO_PORT_RIGHT    1'h1
`define RPIO_REG_DATA      1'h0
`define RPIO_REG_DIR       1'h1

// reset values
`define RPIO_DATA_RST      8'h00
`define RPIO_DIR_RST       8'h00

// field widths
`define RPIO_PORT_W        8
`define RPIO_SEL_W         4
`define RPIO_PORTS         2

// width of the pin bundle passed through the synchroniser
`define RPIO_SYNC_W        38

`endif

// [hw/rpio_pkg.sv]
// Purpose: types of the relay panel port block
// Assumes: rpio_params.svh supplies the widths
// Notes:   one-hot bus cycle states
`include "rpio_params.svh"

package rpio_pkg;

    typedef logic [`RPIO_PORT_W-1:0] rpio_byte_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_WRITE = 3'h2,
        ST_READ  = 3'h4
    } rpio_state_type;

endpackage

// [hw/rpio_sync.sv]
// Purpose: two-flop synchroniser for the asynchronous panel pins
// Assumes: every bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
`include "rpio_params.svh"

module rpio_sync
    import rpio_pkg::*;
#(
    parameter int WIDTH = `RPIO_SYNC_W
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pinIn,
    output var  logic [WIDTH-1:0] pinSync
);

    logic [WIDTH-1:0] stage1_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1_r <= '0;
            pinSync  <= '0;
        end else begin
            stage1_r <= pinIn;
            pinSync  <= stage1_r;
        end
    end

endmodule

`default_nettype wire

// [verification/rpio_host_model.sv]
// Purpose: host card model that drives the panel bus pins
// Assumes: strobes active high; pins move at the falling clk edge
// Notes:   released data lines read FF through the bus terminators
`timescale 1ns/1ps
`default_nettype none

module rpio_host_model
    import rpio_pkg::*;
(
    input  wire logic          clk,
    input  wire rpio_byte_type busDataOut,
    input  wire logic          busDataOe,
    output var  logic          rdStb,
    output var  logic          wrStb,
    output var  logic          a5,
    output var  logic          a0,
    output var  logic [3:0]    sel,
    output var  rpio_byte_type wrData
);
    rpio_byte_type busLevel;

    // an undriven bus is pulled to all ones
    assign busLevel = (busDataOe === 1'b1) ? busDataOut : 8'hFF;

    initial begin
        {rdStb, wrStb, a5, a0, sel} = '0;
        wrData = 8'hFF;
    end

    ////////////////////////////////////////////////////////////////////////
    // address and data settle three cycles before any strobe rises
    task automatic setup(input logic [3:0] s, input logic p, input logic r,
                         input rpio_byte_type d);
        @(negedge clk);
        sel = s;
        a5 = p;
        a0 = r;
        wrData = d;
        repeat (3) @(negedge clk);
    endtask

    task automatic doWrite(input logic [3:0] s, input logic p, input logic r,
                           input rpio_byte_type d, output logic oeW);
        setup(s, p, r, d);
        wrStb = 1'b1;
        repeat (6) @(negedge clk);
        oeW = busDataOe;
        wrStb = 1'b0;
        wrData = 8'hFF;
        repeat (4) @(negedge clk);
    endtask

    // fixed window: the answer needs about three cycles through the synchroniser
    task automatic doRead(input logic [3:0] s, input logic p, input logic oeExp,
                          output rpio_byte_type d, output logic ok);
        setup(s, p, 1'b0, 8'hFF);
        rdStb = 1'b1;
        // sampled at the falling edge, where the registered read data is settled
        repeat (10) @(negedge clk);
        d = busLevel;
        ok = (busDataOe === oeExp);
        @(negedge clk);
        rdStb = 1'b0;
        repeat (4) @(negedge clk);
    endtask
endmodule

`default_nettype wire

// [verification/relay_panel_io_port_tb.sv]
// Purpose: self-checking bench of the relay panel port
// Assumes: host model drives the bus; bench drives straps and channels
// Notes:   random data from an xorshift seeded at 95
`timescale 1ns/1ps
`default_nettype none
`include "rpio_params.svh"

module relay_panel_io_port_tb;
    import rpio_pkg::*;

    logic          clk, rst_n, sysRst, failSafe, rdStb, wrStb, a5, a0, oe, oeW, ok;
    logic [3:0]    sel, strap, badSel;
    rpio_byte_type wrData, busOut, lIn, rIn, lDrv, rDrv, rd;
    rpio_byte_type dat [2];
    rpio_byte_type dir [2];
    logic [31:0]   seed = 32'h0000005F;
    int            errTotal = 0;
    int            nTests = 0;

    relay_panel_io_port dut (.clk(clk), .rst_n(rst_n), .systemReset(sysRst),
        .busFailSafe(failSafe), .codedReadStrobe(rdStb), .codedWriteStrobe(wrStb),
        .busAddrBit5(a5), .busAddrBit0(a0), .panelSelBit4(sel[3]),
        .panelSelBit3(sel[2]), .panelSelBit2(sel[1]), .panelSelBit1(sel[0]),
        .strapClosed(strap), .busDataIn(wrData), .busDataOut(busOut),
        .busDataOe(oe), .leftChanIn(lIn), .rightChanIn(rIn),
        .leftRelayDrive(lDrv), .rightRelayDrive(rDrv));

    rpio_host_model host (.clk(clk), .busDataOut(busOut), .busDataOe(oe),
        .rdStb(rdStb), .wrStb(wrStb), .a5(a5), .a0(a0), .sel(sel), .wrData(wrData));

    ////////////////////////////////////////////////////////////////////////
    function automatic rpio_byte_type rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // output channels read their data bit, input channels the live level
    function automatic rpio_byte_type expRd(input int p);
        return (dat[p] & dir[p]) | (~dir[p] & ((p == 1) ? rIn : lIn));
    endfunction

    task automatic chk(input rpio_byte_type got, input rpio_byte_type exp, input string m);
        nTests++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR %0t %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic completeRun();
        $display("checks %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, sysRst, failSafe, strap, lIn, rIn} = '0;
        dat = '{8'h00, 8'h00};
        dir = '{8'h00, 8'h00};
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk(lDrv, 8'h00, "left drive after reset");
        chk({7'h00, oe}, 8'h00, "bus drive after reset");
        for (int k = 0; k < 12; k++) begin
            rd = rnd();
            strap = (k == 0) ? 4'hF : (k == 1) ? 4'h0 : rd[3:0];
            badSel = ~strap ^ (4'h1 << k[1:0]);
            lIn = rnd();
            rIn = rnd();
            for (int p = 0; p < 2; p++) begin
                dat[p] = rnd();
                dir[p] = rnd();
                if (k == 2) dir[p] = 8'hFF;
                host.doWrite(~strap, p[0], `RPIO_REG_DATA, dat[p], oeW);
                chk({7'h00, oeW}, 8'h00, "drive in write");
                host.doWrite(~strap, p[0], `RPIO_REG_DIR, dir[p], oeW);
            end
            chk(lDrv, dat[0] & dir[0], "left drive");
            chk(rDrv, dat[1] & dir[1], "right drive");
            for (int p = 0; p < 2; p++) begin
                host.doRead(~strap, p[0], 1'b1, rd, ok);
                chk(rd, expRd(p), "port read");
                chk({7'h00, ok}, 8'h01, "read drive");
            end
            host.doWrite(badSel, 1'b0, `RPIO_REG_DATA, ~dat[0], oeW);
            chk(lDrv, dat[0] & dir[0], "foreign write");
            host.doRead(badSel, 1'b0, 1'b0, rd, ok);
            chk(rd, 8'hFF, "foreign read");
            chk({7'h00, ok}, 8'h01, "foreign no drive");
        end
        sysRst = 1'b1;
        repeat (6) @(negedge clk);
        sysRst = 1'b0;
        repeat (3) @(negedge clk);
        chk(lDrv | rDrv, 8'h00, "system reset");
        dat = '{8'h00, 8'h00};
        dir = '{8'h00, 8'h00};
        host.doRead(~strap, 1'b0, 1'b1, rd, ok);
        chk(rd, expRd(0), "read after reset");
        host.doWrite(~strap, 1'b1, `RPIO_REG_DATA, 8'hFF, oeW);
        host.doWrite(~strap, 1'b1, `RPIO_REG_DIR, 8'hFF, oeW);
        chk(rDrv, 8'hFF, "all on");
        failSafe = 1'b1;
        repeat (6) @(negedge clk);
        chk(rDrv, 8'h00, "fail-safe clear");
        host.doRead(~strap, 1'b1, 1'b0, rd, ok);
        chk(rd, 8'hFF, "fail-safe read");
        chk({7'h00, ok}, 8'h01, "fail-safe no drive");
        completeRun();
    end
endmodule

`default_nettype wire
